// File: design/sms_pkg.sv
// Package for the stop-mode sequencer: register map, field layout,
// reset values, warm-up cycle counts, state encoding and state record.
// Assumes one clock domain running at the oscillator rate.
package sms_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SMS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SMS_ADDR_STAT = 8'h04;
    localparam logic [7:0] SMS_ADDR_DIV = 8'h08;
    localparam logic [7:0] SMS_ADDR_LATCH = 8'h0C;
    localparam logic [7:0] SMS_ADDR_PC = 8'h10;

    // ------------------------------------------------------------
    // Field positions in stop_control_reg
    // ------------------------------------------------------------
    localparam int SMS_STOP_BIT = 7;
    localparam int SMS_REL_METHOD_BIT = 6;
    localparam int SMS_HOLD_BIT = 4;
    localparam int SMS_WARMUP_LSB = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic SMS_STOP_RST = 1'b0;
    localparam logic SMS_REL_METHOD_RST = 1'b0;
    localparam logic SMS_HOLD_RST = 1'b0;
    localparam logic [1:0] SMS_WARMUP_RST = 2'h0;
    localparam logic SMS_DIVOPT_RST = 1'b0;

    // ------------------------------------------------------------
    // Widths and warm-up counts in oscillator cycles (option clear)
    // ------------------------------------------------------------
    localparam int SMS_N_EXT = 4;
    localparam int SMS_NCH = SMS_N_EXT + 1;
    localparam int SMS_PC_W = 20;
    localparam int SMS_CNT_W = 20;
    localparam logic [19:0] SMS_WU_CYC_00 = 20'h30000;
    localparam logic [19:0] SMS_WU_CYC_01 = 20'h10000;
    localparam logic [19:0] SMS_WU_CYC_10 = 20'h04000;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SMS_RUN = 2'b00,
        SMS_STOP = 2'b01,
        SMS_WARM = 2'b10
    } sms_state_t;

    // ------------------------------------------------------------
    // Whole state of the sequencer
    // ------------------------------------------------------------
    typedef struct packed {
        sms_state_t st;
        logic stop_bit;
        logic release_method_select;
        logic hold;
        logic [1:0] warmup_select;
        logic divopt;
        logic entry_level;
        logic [SMS_CNT_W-1:0] cnt;
        logic [SMS_PC_W-1:0] pc;
        logic [SMS_NCH-1:0][2:0] sync;
        logic [SMS_NCH-1:0] lvl;
        logic [SMS_NCH-1:0] latch;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic osc_run;
        logic core_hold;
        logic tg_clear;
        logic port_hiz;
        logic resume;
    } sms_regs_t;

endpackage

// File: design/sms_stop_sequencer.sv
// Stop-mode sequencer: stop entry, wake by level or edge, warm-up count,
// resume, interrupt latches, all behind an APB slave.
// Assumes pclk is the always-on oscillator-rate clock; osc_run gates the
// core clock outside, presetn is the device reset pin.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module sms_stop_sequencer #(
    parameter logic [19:0] WU_CYC_00 = sms_pkg::SMS_WU_CYC_00,
    parameter logic [19:0] WU_CYC_01 = sms_pkg::SMS_WU_CYC_01,
    parameter logic [19:0] WU_CYC_10 = sms_pkg::SMS_WU_CYC_10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic wake_pin,
    input wire logic [sms_pkg::SMS_N_EXT-1:0] ext_int_pins,
    // Core side
    input wire logic [sms_pkg::SMS_PC_W-1:0] cpu_pc,
    output logic [sms_pkg::SMS_PC_W-1:0] held_pc,
    output logic osc_run,
    output logic core_hold,
    output logic tg_clear,
    output logic port_hiz,
    output logic resume_pulse,
    output logic shared_port_bit,
    output logic [sms_pkg::SMS_NCH-1:0] int_pending
);

    sms_pkg::sms_regs_t q;
    sms_pkg::sms_regs_t n;
    logic [sms_pkg::SMS_NCH-1:0] pin_vec;
    logic [sms_pkg::SMS_NCH-1:0][2:0] sync_nxt;
    logic [sms_pkg::SMS_NCH-1:0] lvl_nxt;
    logic [sms_pkg::SMS_NCH-1:0] lvl_chg;
    logic wake_rise;

    // ------------------------------------------------------------
    // Warm-up length lookup
    // ------------------------------------------------------------
    // Reserved code 11 falls back to the longest length
    function automatic logic [19:0] wu_len(input logic [1:0] sel, input logic dbl);
        logic [19:0] base;
        base = WU_CYC_00;
        case (sel)
            2'h1: base = WU_CYC_01;
            2'h2: base = WU_CYC_10;
            default: base = WU_CYC_00;
        endcase
        wu_len = dbl ? {base[18:0], 1'b0} : base;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers, one per channel; channel 0 is the wake pin
    // ------------------------------------------------------------
    assign pin_vec = {ext_int_pins, wake_pin};

    genvar gi;
    generate
        for (gi = 0; gi < sms_pkg::SMS_NCH; gi++)
        begin : g_ch
            // Three stages; a new level counts once stages two and three agree
            assign sync_nxt[gi] = {q.sync[gi][1:0], pin_vec[gi]};
            assign lvl_nxt[gi] = (q.sync[gi][1] == q.sync[gi][2]) ?
                                 q.sync[gi][2] : q.lvl[gi];
            assign lvl_chg[gi] = lvl_nxt[gi] ^ q.lvl[gi];
        end
    endgenerate

    assign wake_rise = lvl_nxt[0] & ~q.lvl[0];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic setup;
        logic wr;
        logic mapped;
        logic [31:0] rd;
        logic stop_wr;
        setup = psel & ~penable;
        wr = psel & penable & q.pready & pwrite & ~q.pslverr;
        mapped = 1'b1;
        rd = 32'h0;
        stop_wr = 1'b0;
        n = q;
        n.sync = sync_nxt;
        n.lvl = lvl_nxt;

        // Read decode
        case (paddr)
            sms_pkg::SMS_ADDR_CTRL:
            begin
                rd[sms_pkg::SMS_STOP_BIT] = q.stop_bit;
                rd[sms_pkg::SMS_REL_METHOD_BIT] = q.release_method_select;
                rd[sms_pkg::SMS_HOLD_BIT] = q.hold;
                rd[sms_pkg::SMS_WARMUP_LSB +: 2] = q.warmup_select;
            end
            sms_pkg::SMS_ADDR_STAT: rd[3:0] = {q.osc_run, q.lvl[0], q.st};
            sms_pkg::SMS_ADDR_DIV: rd[0] = q.divopt;
            sms_pkg::SMS_ADDR_LATCH: rd[sms_pkg::SMS_NCH-1:0] = q.latch;
            sms_pkg::SMS_ADDR_PC: rd[sms_pkg::SMS_PC_W-1:0] = q.pc;
            default: mapped = 1'b0;
        endcase

        // APB answer one cycle after setup
        n.pready = setup;
        n.pslverr = setup & ~mapped;
        n.prdata = (setup & mapped & ~pwrite) ? rd : 32'h0;

        // Latch clear by write-one; a change in the same cycle still sets
        if (wr && paddr == sms_pkg::SMS_ADDR_LATCH)
        begin
            n.latch = q.latch & ~pwdata[sms_pkg::SMS_NCH-1:0];
        end
        n.latch = n.latch | lvl_chg;

        // Configuration writes only while running; kept frozen otherwise
        if (wr && q.st == sms_pkg::SMS_RUN)
        begin
            if (paddr == sms_pkg::SMS_ADDR_CTRL)
            begin
                n.release_method_select = pwdata[sms_pkg::SMS_REL_METHOD_BIT];
                n.hold = pwdata[sms_pkg::SMS_HOLD_BIT];
                n.warmup_select = pwdata[sms_pkg::SMS_WARMUP_LSB +: 2];
                stop_wr = pwdata[sms_pkg::SMS_STOP_BIT];
            end
            if (paddr == sms_pkg::SMS_ADDR_DIV)
            begin
                n.divopt = pwdata[0];
            end
        end

        // Sequencer
        case (q.st)
            sms_pkg::SMS_RUN:
            begin
                if (stop_wr)
                begin
                    n.stop_bit = 1'b1;
                    n.pc = cpu_pc;
                    n.entry_level = n.release_method_select;
                    if (n.release_method_select && lvl_nxt[0])
                    begin
                        // Level mode with pin already high skips the stop
                        n.st = sms_pkg::SMS_WARM;
                        n.cnt = wu_len(n.warmup_select, n.divopt) - 20'h1;
                    end
                    else
                    begin
                        n.st = sms_pkg::SMS_STOP;
                    end
                end
            end
            sms_pkg::SMS_STOP:
            begin
                // Level wake only if stop was entered in level mode
                if (wake_rise ||
                    (q.entry_level && q.release_method_select && lvl_nxt[0]))
                begin
                    n.st = sms_pkg::SMS_WARM;
                    n.cnt = wu_len(q.warmup_select, q.divopt) - 20'h1;
                end
            end
            sms_pkg::SMS_WARM:
            begin
                // Counted in oscillator cycles, pin ignored until done
                if (q.cnt == 20'h0)
                begin
                    n.st = sms_pkg::SMS_RUN;
                    n.stop_bit = 1'b0;
                end
                else
                begin
                    n.cnt = q.cnt - 20'h1;
                end
            end
            default: n.st = sms_pkg::SMS_RUN;
        endcase

        // Registered outputs derived from next state
        n.osc_run = n.st != sms_pkg::SMS_STOP;
        n.core_hold = n.st != sms_pkg::SMS_RUN;
        n.tg_clear = n.st != sms_pkg::SMS_RUN;
        n.port_hiz = (n.st == sms_pkg::SMS_STOP) & ~n.hold;
        n.resume = (q.st == sms_pkg::SMS_WARM) & (n.st == sms_pkg::SMS_RUN);
    end

    // ------------------------------------------------------------
    // State register; reset pin aborts any stop at once
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.st <= sms_pkg::SMS_RUN;
            q.stop_bit <= sms_pkg::SMS_STOP_RST;
            q.release_method_select <= sms_pkg::SMS_REL_METHOD_RST;
            q.hold <= sms_pkg::SMS_HOLD_RST;
            q.warmup_select <= sms_pkg::SMS_WARMUP_RST;
            q.divopt <= sms_pkg::SMS_DIVOPT_RST;
            q.osc_run <= 1'b1;
        end
        else
        begin
            q <= n;
        end
    end

    // Output map
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign held_pc = q.pc;
    assign osc_run = q.osc_run;
    assign core_hold = q.core_hold;
    assign tg_clear = q.tg_clear;
    assign port_hiz = q.port_hiz;
    assign resume_pulse = q.resume;
    assign shared_port_bit = q.lvl[0];
    assign int_pending = q.latch;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_stop_entry;
        @(posedge pclk) disable iff (!presetn)
        (q.st == sms_pkg::SMS_RUN && psel && penable && q.pready && pwrite &&
         !q.pslverr && paddr == sms_pkg::SMS_ADDR_CTRL &&
         pwdata[sms_pkg::SMS_STOP_BIT] && !pwdata[sms_pkg::SMS_REL_METHOD_BIT])
        |=> q.st == sms_pkg::SMS_STOP && q.stop_bit && !osc_run;
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");

    property p_osc_off;
        @(posedge pclk) disable iff (!presetn)
        q.st == sms_pkg::SMS_STOP |-> !osc_run && core_hold && tg_clear;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("clock running in stop");

    property p_cfg_frozen;
        @(posedge pclk) disable iff (!presetn)
        q.st != sms_pkg::SMS_RUN
        |=> $stable(q.warmup_select) && $stable(q.divopt) && $stable(q.pc);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen) else $error("state changed in stop");

    property p_pc_capture;
        @(posedge pclk) disable iff (!presetn)
        ($past(q.st) == sms_pkg::SMS_RUN && q.st != sms_pkg::SMS_RUN)
        |-> held_pc == $past(cpu_pc);
    endproperty
    a_pc_capture: assert property (p_pc_capture) else $error("pc not held");

    property p_level_skip;
        @(posedge pclk) disable iff (!presetn)
        ($past(q.st) == sms_pkg::SMS_RUN && q.st != sms_pkg::SMS_RUN &&
         q.release_method_select && q.lvl[0])
        |-> q.st == sms_pkg::SMS_WARM;
    endproperty
    a_level_skip: assert property (p_level_skip) else $error("stop entered with pin high");

    property p_no_restop;
        @(posedge pclk) disable iff (!presetn)
        q.st == sms_pkg::SMS_WARM |=> q.st != sms_pkg::SMS_STOP;
    endproperty
    a_no_restop: assert property (p_no_restop) else $error("returned to stop");

    property p_edge_wait;
        @(posedge pclk) disable iff (!presetn)
        (q.st == sms_pkg::SMS_STOP && !q.entry_level && !wake_rise)
        |=> q.st == sms_pkg::SMS_STOP;
    endproperty
    a_edge_wait: assert property (p_edge_wait) else $error("left stop without edge");

    property p_warm_len;
        @(posedge pclk) disable iff (!presetn)
        ($past(q.st) != sms_pkg::SMS_WARM && q.st == sms_pkg::SMS_WARM)
        |-> q.cnt == wu_len(q.warmup_select, q.divopt) - 20'h1;
    endproperty
    a_warm_len: assert property (p_warm_len) else $error("wrong warm-up length");

    property p_resume;
        @(posedge pclk) disable iff (!presetn)
        (q.st == sms_pkg::SMS_WARM && q.cnt == 20'h0)
        |=> resume_pulse && !q.stop_bit && !tg_clear && !core_hold ##1 !resume_pulse;
    endproperty
    a_resume: assert property (p_resume) else $error("bad resume");

    property p_latch_set;
        @(posedge pclk) disable iff (!presetn)
        lvl_chg[0] |=> int_pending[0];
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("pin change lost");

    property p_hiz;
        @(posedge pclk) disable iff (!presetn)
        q.st == sms_pkg::SMS_STOP |-> port_hiz == !q.hold;
    endproperty
    a_hiz: assert property (p_hiz) else $error("port state wrong in stop");

    // A level-entered stop must leave on the filtered high level
    property p_level_wake;
        @(posedge pclk) disable iff (!presetn)
        (q.st == sms_pkg::SMS_STOP && q.entry_level && q.release_method_select && lvl_nxt[0])
        |=> q.st == sms_pkg::SMS_WARM && osc_run;
    endproperty
    a_level_wake: assert property (p_level_wake) else $error("level wake missed");

    // Any filtered rising edge ends a stop, whatever the mode
    property p_edge_wake;
        @(posedge pclk) disable iff (!presetn)
        (q.st == sms_pkg::SMS_STOP && wake_rise) |=> q.st == sms_pkg::SMS_WARM && osc_run;
    endproperty
    a_edge_wake: assert property (p_edge_wake) else $error("edge wake missed");

    // Warm-up counter steps down by one per oscillator cycle
    property p_warm_step;
        @(posedge pclk) disable iff (!presetn)
        (q.st == sms_pkg::SMS_WARM && q.cnt != 20'h0)
        |=> q.st == sms_pkg::SMS_WARM && q.cnt == $past(q.cnt) - 20'h1;
    endproperty
    a_warm_step: assert property (p_warm_step) else $error("warm-up count skipped");

    // Oscillator up but core and timing generator still held in warm-up
    property p_warm_idle;
        @(posedge pclk) disable iff (!presetn)
        q.st == sms_pkg::SMS_WARM |-> osc_run && core_hold && tg_clear && !port_hiz;
    endproperty
    a_warm_idle: assert property (p_warm_idle) else $error("core active in warm-up");

    // A wake level only counts once stages two and three agree
    property p_pin_filter;
        @(posedge pclk) disable iff (!presetn)
        (q.sync[0][1] != q.sync[0][2]) |=> $stable(shared_port_bit);
    endproperty
    a_pin_filter: assert property (p_pin_filter) else $error("wake pin not filtered");

    // Write-one clears a latch when its pin is quiet in that cycle
    property p_latch_clear;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && q.pready && pwrite && !q.pslverr &&
         paddr == sms_pkg::SMS_ADDR_LATCH && pwdata[0] && !lvl_chg[0])
        |=> !int_pending[0];
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

    // Fixed bus answer: ready in the cycle after each setup, then low
    property p_apb_ready;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("bus answer not one cycle");

endmodule

// File: bench/sms_wake_src.sv
// Far-side model: the source driving the wake pin and the four
// external interrupt pins.
// Assumes the bench commands the pin levels it wants at pclk edges.
`timescale 1ns/1ps
module sms_wake_src #(
    parameter int DLY = 2
) (
    // Clock and command
    input wire logic pclk,
    input wire logic want_wake,
    input wire logic [3:0] want_ext,
    // Pins
    output logic wake_pin,
    output logic [3:0] ext_int_pins
);
    logic [DLY-1:0] wake_dl = '0;
    logic [DLY-1:0][3:0] ext_dl = '0;

    // Pins follow the command after DLY cycles, like a slow source
    always @(posedge pclk)
    begin
        wake_dl <= {wake_dl[DLY-2:0], want_wake};
        ext_dl <= {ext_dl[DLY-2:0], want_ext};
    end

    // A level is held until commanded away, so a level wake can be seen
    assign wake_pin = wake_dl[DLY-1];
    assign ext_int_pins = ext_dl[DLY-1];
endmodule

// File: bench/stop_mode_sequencer_tb.sv
// Testbench for the stop-mode sequencer: APB master tasks, one task per
// scenario, wake source model on the pins.
// Assumes small warm-up counts handed to the design as parameters.
`timescale 1ns/1ps
module stop_mode_sequencer_tb;
    localparam logic [19:0] C00 = 20'h00030;
    localparam logic [19:0] C01 = 20'h00010;
    localparam logic [19:0] C10 = 20'h00004;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic want_wake = 1'b0;
    logic [3:0] want_ext = 4'h0;
    logic wake_pin;
    logic [3:0] ext_int_pins;
    logic [19:0] cpu_pc = 20'h00000;
    logic [19:0] held_pc;
    logic osc_run, core_hold, tg_clear, port_hiz, resume_pulse, shared_port_bit;
    logic [4:0] int_pending;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int tests_run = 0;

    always #12.5 pclk = ~pclk;

    sms_wake_src i_src (.pclk(pclk), .want_wake(want_wake), .want_ext(want_ext),
        .wake_pin(wake_pin), .ext_int_pins(ext_int_pins));

    sms_stop_sequencer #(.WU_CYC_00(C00), .WU_CYC_01(C01), .WU_CYC_10(C10)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin),
        .ext_int_pins(ext_int_pins), .cpu_pc(cpu_pc), .held_pc(held_pc),
        .osc_run(osc_run), .core_hold(core_hold), .tg_clear(tg_clear),
        .port_hiz(port_hiz), .resume_pulse(resume_pulse),
        .shared_port_bit(shared_port_bit), .int_pending(int_pending));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            bad_count++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // Counts warm-up cycles (oscillator on, core held) up to the resume pulse
    task automatic warm_len(input int exp);
        int n;
        int k;
        n = 0;
        k = 0;
        #1;
        while (resume_pulse !== 1'b1 && k < 600)
        begin
            if (core_hold === 1'b1 && osc_run === 1'b1)
                n++;
            @(posedge pclk);
            #1;
            k++;
        end
        if (k >= 600)
        begin
            bad_count++;
            tally_and_finish();
        end
        chk("warm-up length", exp, n);
        chk("core released", 1'b0, core_hold);
        chk("prescaler free", 1'b0, tg_clear);
        cycles(1);
        chk("resume one cycle", 1'b0, resume_pulse);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        apb(1'b0, sms_pkg::SMS_ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, sms_pkg::SMS_ADDR_STAT, 32'h0);
        chk("stat reset", 32'h8, rd);
        apb(1'b1, 8'h14, 32'hFF);
        chk("unmapped error", 1'b1, err);
        $display("test reset done");
    endtask

    // Edge mode: stop with the pin high, stays stopped, wakes on a rise
    task automatic t_edge;
        want_wake <= 1'b1;
        cpu_pc <= 20'hABCDE;
        cycles(8);
        chk("port bit", 1'b1, shared_port_bit);
        apb(1'b1, sms_pkg::SMS_ADDR_CTRL, 32'h98);
        #1;
        chk("osc stopped", 1'b0, osc_run);
        chk("core held", 1'b1, core_hold);
        chk("prescaler cleared", 1'b1, tg_clear);
        chk("ports held", 1'b0, port_hiz);
        chk("held pc", 20'hABCDE, held_pc);
        cycles(10);
        chk("no wake on level", 1'b0, osc_run);
        apb(1'b0, sms_pkg::SMS_ADDR_CTRL, 32'h0);
        chk("ctrl in stop", 32'h98, rd);
        apb(1'b0, sms_pkg::SMS_ADDR_PC, 32'h0);
        chk("pc register", 32'hABCDE, rd);
        want_wake <= 1'b0;
        cycles(8);
        want_wake <= 1'b1;
        warm_len(C10);
        apb(1'b0, sms_pkg::SMS_ADDR_CTRL, 32'h0);
        chk("stop bit cleared", 32'h18, rd);
        $display("test edge done");
    endtask

    // Level mode with the pin high: each code goes straight to warm-up
    task automatic t_codes;
        logic [19:0] tab [4];
        tab = '{C00, C01, C10, C00};
        for (int dv = 0; dv < 2; dv++)
        begin
            apb(1'b1, sms_pkg::SMS_ADDR_DIV, 32'(dv));
            for (int c = 0; c < 4; c++)
            begin
                apb(1'b1, sms_pkg::SMS_ADDR_CTRL, 32'hC0 | 32'(c << 2));
                #1;
                chk("no stop", 1'b1, osc_run);
                warm_len(int'(tab[c]) << dv);
            end
        end
        apb(1'b1, sms_pkg::SMS_ADDR_DIV, 32'h0);
        $display("test codes done");
    endtask

    // Level wake with pin dropped in warm-up, interrupt latches in stop
    task automatic t_level;
        want_wake <= 1'b0;
        cycles(8);
        apb(1'b1, sms_pkg::SMS_ADDR_LATCH, 32'h1F);
        apb(1'b1, sms_pkg::SMS_ADDR_CTRL, 32'hC0);
        #1;
        chk("level stop", 1'b0, osc_run);
        chk("ports floated", 1'b1, port_hiz);
        want_ext <= 4'hF;
        cycles(10);
        chk("latched in stop", 5'h1E, int_pending);
        want_wake <= 1'b1;
        cycles(8);
        want_wake <= 1'b0;
        warm_len(int'(C00) - 2);
        apb(1'b0, sms_pkg::SMS_ADDR_LATCH, 32'h0);
        chk("latch read", 32'h1F, rd);
        apb(1'b1, sms_pkg::SMS_ADDR_LATCH, 32'h1F);
        apb(1'b0, sms_pkg::SMS_ADDR_LATCH, 32'h0);
        chk("latch cleared", 32'h0, rd);
        want_ext <= 4'h0;
        cycles(8);
        $display("test level done");
    endtask

    // Reset pin during stop returns to normal at once
    task automatic t_abort;
        apb(1'b1, sms_pkg::SMS_ADDR_CTRL, 32'h80);
        #1;
        chk("stopped", 1'b0, osc_run);
        @(posedge pclk);
        presetn <= 1'b0;
        cycles(1);
        chk("reset runs osc", 1'b1, osc_run);
        chk("reset frees core", 1'b0, core_hold);
        @(posedge pclk);
        presetn <= 1'b1;
        cycles(6);
        apb(1'b0, sms_pkg::SMS_ADDR_STAT, 32'h0);
        chk("normal after reset", 32'h8, rd);
        $display("test abort done");
    endtask

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_edge();
        t_codes();
        t_level();
        t_abort();
        tally_and_finish();
    end
endmodule
